// file: bert_pkg.sv
// bert_pkg: constants, types and generator functions of the bit error rate tester
// How it works
// - prbs polynomial, length, tap, seed programmable
// - repetitive pattern length and value programmable
// - 24-bit error and 32-bit bit counters
// - error insertion: single, pin edge, rate
// - lock holds despite sparse random errors
// - pattern load ignored while tester disabled
// - pattern load acts on rising edge only
// - 2047 pattern control 080a, seeds ffff
// - alternating pattern control 0021, seed fffe
// - error flag set when error count nonzero
// - out of lock flag while unsynchronised
// - monitor update copies counts, restarts counters
// - stream feeds tester and processor fifo
// - only payload bits are compared
// - 32-bit generator shifting toward bit 32
// - feedback from taps, output equals feedback except for the quasi random fill
// - quasi random taps 17, 20, ones fill
// - all-zero lower 31 bits force feedback one, except in repetitive mode
// - pattern type selects synchronisation procedure
// - load 32 bits then 32 clean matches
// - six errors per window start resync, disableable
// - repetitive hunt slips, then 32 matches
// - counts advance only while locked
// - new load presets generator with seed
package bert_pkg;
    // ************************************************************
    // field layout of the pattern control word
    // ************************************************************
    localparam int PCR_LEN_LSB = 0;
    localparam int PCR_PTS_BIT = 5;
    localparam int PCR_QUASI_RANDOM_MODE_BIT = 6;
    localparam int PCR_TAP_LSB = 8;
    localparam int FIELD_W = 5;
    localparam logic [15:0] PCR_PRBS_2047 = 16'h080a;
    localparam logic [15:0] PCR_ALTERNATE = 16'h0021;
    localparam logic [15:0] SEED_ALL_ONES = 16'hffff;
    localparam logic [15:0] SEED_ALT_LOW = 16'hfffe;

    // ************************************************************
    // generator and synchroniser figures
    // ************************************************************
    localparam int GEN_W = 32;
    localparam int BIT_CNT_W = 32;
    localparam int ERR_CNT_W = 24;
    localparam int QUASI_RANDOM_MODE_TAP_A = 17;
    localparam int QUASI_RANDOM_MODE_TAP_B = 20;
    localparam int QUASI_RANDOM_MODE_ZERO_RUN = 14;
    localparam int ALLZERO_BITS = 31;
    localparam int SYNC_BITS = 32;
    localparam int WIN_BITS = 64;
    localparam int WIN_ERR_LIMIT = 6;
    localparam int RATE_MAX = 7;

    typedef enum logic [1:0] {
        BERT_ST_LOAD = 2'b00,
        BERT_ST_CHECK = 2'b01,
        BERT_ST_SYNC = 2'b11,
        BERT_ST_HUNT = 2'b10
    } bert_sync_t;

    typedef struct packed {
        logic [GEN_W-1:0] tx_gen;
        logic tx_bit;
        logic tx_load_q;
        logic sw_err_q;
        logic man_err_q;
        logic err_pend;
        logic [ERR_CNT_W-1:0] rate_cnt;
        logic [GEN_W-1:0] rx_gen;
        bert_sync_t rx_st;
        logic [4:0] rx_cnt;
        logic [5:0] win_cnt;
        logic [2:0] win_err;
        logic rx_load_q;
        logic pmu_q;
        logic [BIT_CNT_W-1:0] bit_run;
        logic [ERR_CNT_W-1:0] err_run;
        logic [BIT_CNT_W-1:0] bit_reg;
        logic [ERR_CNT_W-1:0] err_reg;
        logic err_flag;
        logic oos_flag;
        logic [6:0] shreg;
        logic [2:0] shcnt;
    } bert_state_t;

    // nothing is locked out of reset, so the out of lock flag starts high
    localparam bert_state_t BERT_STATE_RST = '{rx_st: BERT_ST_LOAD, oos_flag: 1'b1, default: '0};

    // feedback value; bit k of the text is index k-1
    function automatic logic gen_fb(input logic [GEN_W-1:0] g, input logic [15:0] pcr);
        logic [4:0] n;
        logic [4:0] y;
        logic fb;
        n = pcr[PCR_LEN_LSB +: FIELD_W];
        y = pcr[PCR_TAP_LSB +: FIELD_W];
        if (pcr[PCR_QUASI_RANDOM_MODE_BIT]) begin
            fb = g[QUASI_RANDOM_MODE_TAP_A-1] ^ g[QUASI_RANDOM_MODE_TAP_B-1];
        end else if (pcr[PCR_PTS_BIT]) begin
            fb = g[n];
        end else begin
            fb = g[n] ^ g[y];
        end
        if (!pcr[PCR_PTS_BIT] && (g[ALLZERO_BITS-1:0] == '0)) begin
            fb = 1'b1;
        end
        return fb;
    endfunction

    // pattern bit; quasi random fills long zero runs with a one
    function automatic logic gen_out(input logic [GEN_W-1:0] g, input logic [15:0] pcr);
        return gen_fb(g, pcr) | (pcr[PCR_QUASI_RANDOM_MODE_BIT] & (g[QUASI_RANDOM_MODE_ZERO_RUN-1:0] == '0));
    endfunction

    // bits between inserted errors; zero means off
    function automatic logic [ERR_CNT_W-1:0] rate_period(input logic [2:0] n);
        logic [ERR_CNT_W-1:0] p;
        unique case (n)
            3'h1: p = 24'h00000a;
            3'h2: p = 24'h000064;
            3'h3: p = 24'h0003e8;
            3'h4: p = 24'h002710;
            3'h5: p = 24'h0186a0;
            3'h6: p = 24'h0f4240;
            3'h7: p = 24'h989680;
            default: p = 24'h000000;
        endcase
        return p;
    endfunction
endpackage

// file: bert_top.sv
// bert_top: pattern generator, receive synchroniser, counters and processor fifo
`timescale 1ns/100ps

// ************************************************************
// small synchronous fifo
// ************************************************************
module bert_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,              // clock
    input wire logic rst_n_i,            // async reset, low
    input wire logic flush_i,            // drop all contents
    input wire logic in_valid_i,         // write request
    input wire logic [WIDTH-1:0] in_data_i, // write data
    output logic in_ready_o,             // space left
    output logic out_valid_o,            // data available
    output logic [WIDTH-1:0] out_data_o, // head word
    input wire logic out_ready_i         // reader takes head
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } bert_fifo_state_t;

    bert_fifo_state_t q;
    bert_fifo_state_t d;
    logic push;
    logic pop;

    if ((DEPTH < 2) || ((1 << AW) != DEPTH) || (WIDTH < 1)) begin : g_chk
        $error("fifo depth must be a power of two of at least 2");
    end

    // full and empty straight from the occupancy count
    assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o = q.mem[q.rd];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // pointer and count update
    always_comb begin
        d = q;
        if (flush_i) begin
            d.wr = '0;
            d.rd = '0;
            d.cnt = '0;
        end else begin
            if (push) begin
                d.mem[q.wr] = in_data_i;
                d.wr = q.wr + 1'b1;
            end
            if (pop) begin
                d.rd = q.rd + 1'b1;
            end
            d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// ************************************************************
// tester top
// ************************************************************
module bert_top #(
    parameter int FIFO_WIDTH = 8,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic MCLK_I,                   // datapath clock, 40 MHz
    input wire logic RST_N_I,                  // async reset, low
    input wire logic TESTER_ENABLE_I,          // tester enable
    input wire logic [15:0] PATTERN_CTRL_I,    // length, type, quasi, tap
    input wire logic [15:0] SEED_LOW_I,        // seed bits 16..1
    input wire logic [15:0] SEED_HIGH_I,       // seed bits 32..17
    input wire logic TX_NEW_PATTERN_LOAD_I,    // tx load, rising edge
    input wire logic RX_NEW_PATTERN_LOAD_I,    // rx load, rising edge
    input wire logic TX_PATTERN_INVERT_I,      // invert tx pattern
    input wire logic RX_PATTERN_INVERT_I,      // invert rx compare
    input wire logic AUTO_RESYNC_DIS_I,        // stop automatic resync
    input wire logic [2:0] ERROR_RATE_I,       // 0 off, n: one per 10^n
    input wire logic ERROR_SRC_PIN_I,          // 1: pin, 0: software bit
    input wire logic SINGLE_ERROR_I,           // software single error, rising
    input wire logic MANUAL_ERROR_INPUT_I,     // manual error pin, rising
    input wire logic LOCAL_MONITOR_UPDATE_I,   // counter update, rising
    input wire logic RX_FIFO_RESET_I,          // hold processor fifo in reset
    input wire logic TX_SLOT_I,                // framer wants a payload bit
    output logic TX_DATA_O,                    // pattern bit, valid after slot
    input wire logic RX_VALID_I,               // incoming bit present
    input wire logic RX_DATA_I,                // incoming bit
    input wire logic RX_PAYLOAD_I,             // bit is payload, not overhead
    output logic RX_READY_O,                   // incoming bit accepted
    output logic CP_VALID_O,                   // processor byte valid
    output logic [FIFO_WIDTH-1:0] CP_DATA_O,   // processor byte, first bit msb
    input wire logic CP_READY_I,               // processor takes byte
    output logic ERROR_PRESENT_FLAG_O,         // error counter nonzero
    output logic OUT_OF_LOCK_FLAG_O,           // receive not synchronised
    output logic [31:0] BIT_COUNT_O,           // latched bit count
    output logic [23:0] ERROR_COUNT_O          // latched error count
);
    localparam logic [4:0] CNT_LAST = 5'(bert_pkg::SYNC_BITS - 1);
    localparam logic [5:0] WIN_LAST = 6'(bert_pkg::WIN_BITS - 1);
    localparam logic [2:0] WIN_LIM = 3'(bert_pkg::WIN_ERR_LIMIT);

    if (FIFO_WIDTH != 8) begin : g_chk
        $error("byte packer serves a fifo width of 8 only");
    end

    bert_pkg::bert_state_t q;
    bert_pkg::bert_state_t d;
    logic [31:0] seed;
    logic rep_mode;
    logic tx_load_rise;
    logic rx_load_rise;
    logic pmu_rise;
    logic err_edge;
    logic tx_take;
    logic rate_hit;
    logic [23:0] rate_lim;
    logic rx_take;
    logic rx_bit;
    logic rx_din;
    logic rx_exp;
    logic rx_fb;
    logic rx_miss;
    logic [2:0] win_err_n;
    logic count_bit;
    logic count_err;
    logic fifo_in_ready;
    logic fifo_push;
    logic [FIFO_WIDTH-1:0] fifo_data;
    bert_pkg::bert_sync_t hunt_st;

    assign seed = {SEED_HIGH_I, SEED_LOW_I};
    assign rep_mode = PATTERN_CTRL_I[bert_pkg::PCR_PTS_BIT];
    assign hunt_st = rep_mode ? bert_pkg::BERT_ST_HUNT : bert_pkg::BERT_ST_LOAD;
    assign tx_load_rise = TX_NEW_PATTERN_LOAD_I & ~q.tx_load_q;
    assign rx_load_rise = RX_NEW_PATTERN_LOAD_I & ~q.rx_load_q;
    assign pmu_rise = LOCAL_MONITOR_UPDATE_I & ~q.pmu_q;
    assign err_edge = ERROR_SRC_PIN_I ? (MANUAL_ERROR_INPUT_I & ~q.man_err_q) :
                                        (SINGLE_ERROR_I & ~q.sw_err_q);
    assign rate_lim = bert_pkg::rate_period(ERROR_RATE_I);
    assign rate_hit = (rate_lim != '0) && (q.rate_cnt == rate_lim - 24'h000001);
    assign tx_take = TESTER_ENABLE_I & ~tx_load_rise & TX_SLOT_I;

    // stream shared by tester and fifo; fifo reset frees the stream
    assign RX_READY_O = fifo_in_ready | RX_FIFO_RESET_I;
    assign rx_take = RX_VALID_I & RX_READY_O;
    // overhead and stuff bits never reach the comparator
    assign rx_bit = rx_take & RX_PAYLOAD_I;
    assign rx_din = RX_DATA_I ^ RX_PATTERN_INVERT_I;
    assign rx_fb = bert_pkg::gen_fb(q.rx_gen, PATTERN_CTRL_I);
    assign rx_exp = bert_pkg::gen_out(q.rx_gen, PATTERN_CTRL_I);
    assign rx_miss = rx_bit & (rx_din != rx_exp);
    assign win_err_n = (q.win_err == WIN_LIM) ? WIN_LIM : q.win_err + {2'b00, rx_miss};
    assign fifo_push = rx_take & RX_PAYLOAD_I & (q.shcnt == 3'h7) & ~RX_FIFO_RESET_I;
    assign fifo_data = {q.shreg, RX_DATA_I};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d = q;
        count_bit = 1'b0;
        count_err = 1'b0;
        d.tx_load_q = TX_NEW_PATTERN_LOAD_I;
        d.rx_load_q = RX_NEW_PATTERN_LOAD_I;
        d.sw_err_q = SINGLE_ERROR_I;
        d.man_err_q = MANUAL_ERROR_INPUT_I;
        d.pmu_q = LOCAL_MONITOR_UPDATE_I;

        // transmit generator; a disabled tester sends zeros and holds its state
        if (!TESTER_ENABLE_I) begin
            d.tx_bit = 1'b0;
        end else if (tx_load_rise) begin
            d.tx_gen = seed;
            d.rate_cnt = '0;
        end else if (TX_SLOT_I) begin
            // pending single or rate error flips one bit
            d.tx_bit = bert_pkg::gen_out(q.tx_gen, PATTERN_CTRL_I) ^
                       (q.err_pend | rate_hit) ^ TX_PATTERN_INVERT_I;
            d.tx_gen = {q.tx_gen[30:0], bert_pkg::gen_fb(q.tx_gen, PATTERN_CTRL_I)};
            d.rate_cnt = (rate_hit || (rate_lim == '0)) ? '0 : q.rate_cnt + 24'h000001;
        end
        // a new request in the consuming cycle is kept for the next slot
        d.err_pend = (q.err_pend & ~tx_take) | err_edge;

        // receive synchroniser
        if (!TESTER_ENABLE_I) begin
            d.rx_st = bert_pkg::BERT_ST_LOAD;
            d.rx_cnt = '0;
        end else if (rx_load_rise) begin
            d.rx_gen = seed;
            d.rx_st = hunt_st;
            d.rx_cnt = '0;
        end else if (rx_bit) begin
            unique case (q.rx_st)
                bert_pkg::BERT_ST_LOAD: begin
                    d.rx_gen = {q.rx_gen[30:0], rx_din};
                    d.rx_cnt = q.rx_cnt + 5'h01;
                    if (q.rx_cnt == CNT_LAST) begin
                        d.rx_st = bert_pkg::BERT_ST_CHECK;
                    end
                end
                bert_pkg::BERT_ST_CHECK: begin
                    d.rx_gen = {q.rx_gen[30:0], rx_fb};
                    d.rx_cnt = rx_miss ? 5'h00 : q.rx_cnt + 5'h01;
                    if (rx_miss) begin
                        d.rx_st = bert_pkg::BERT_ST_LOAD;
                    end else if (q.rx_cnt == CNT_LAST) begin
                        d.rx_st = bert_pkg::BERT_ST_SYNC;
                    end
                end
                bert_pkg::BERT_ST_HUNT: begin
                    // holding the generator slips one bit position
                    d.rx_cnt = rx_miss ? 5'h00 : q.rx_cnt + 5'h01;
                    if (!rx_miss) begin
                        d.rx_gen = {q.rx_gen[30:0], rx_fb};
                    end
                    if (!rx_miss && (q.rx_cnt == CNT_LAST)) begin
                        d.rx_st = bert_pkg::BERT_ST_SYNC;
                    end
                end
                bert_pkg::BERT_ST_SYNC: begin
                    // free running; isolated errors never break lock
                    d.rx_gen = {q.rx_gen[30:0], rx_fb};
                    count_bit = 1'b1;
                    count_err = rx_miss;
                    d.win_cnt = q.win_cnt + 6'h01;
                    d.win_err = (q.win_cnt == WIN_LAST) ? 3'h0 : win_err_n;
                    // six misses in window force resync
                    if ((win_err_n == WIN_LIM) && !AUTO_RESYNC_DIS_I) begin
                        d.rx_st = hunt_st;
                        d.rx_cnt = '0;
                    end
                end
            endcase
        end
        if (d.rx_st != bert_pkg::BERT_ST_SYNC) begin
            d.win_cnt = '0;
            d.win_err = '0;
        end

        // update latches counts; this cycle's event starts the new run
        if (pmu_rise) begin
            d.bit_reg = q.bit_run;
            d.err_reg = q.err_run;
            d.bit_run = {31'h00000000, count_bit};
            d.err_run = {23'h000000, count_err};
        end else begin
            if (count_bit && (q.bit_run != '1)) begin
                d.bit_run = q.bit_run + 32'h00000001;
            end
            if (count_err && (q.err_run != '1)) begin
                d.err_run = q.err_run + 24'h000001;
            end
        end
        d.err_flag = (d.err_run != '0);
        d.oos_flag = (d.rx_st != bert_pkg::BERT_ST_SYNC);

        // byte packing for the processor, first bit ends up in the msb
        if (RX_FIFO_RESET_I) begin
            d.shcnt = '0;
        end else if (rx_take && RX_PAYLOAD_I) begin
            d.shreg = {q.shreg[5:0], RX_DATA_I};
            d.shcnt = q.shcnt + 3'h1;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            q <= bert_pkg::BERT_STATE_RST;
        end else begin
            q <= d;
        end
    end

    // processor path buffer; its full flag stalls the whole receive stream
    bert_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .flush_i(RX_FIFO_RESET_I),
        .in_valid_i(fifo_push),
        .in_data_i(fifo_data),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(CP_VALID_O),
        .out_data_o(CP_DATA_O),
        .out_ready_i(CP_READY_I)
    );

    assign TX_DATA_O = q.tx_bit;
    assign ERROR_PRESENT_FLAG_O = q.err_flag;
    assign OUT_OF_LOCK_FLAG_O = q.oos_flag;
    assign BIT_COUNT_O = q.bit_reg;
    assign ERROR_COUNT_O = q.err_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_load_ignored;
        (rx_load_rise && !TESTER_ENABLE_I) |=> (q.rx_gen == $past(q.rx_gen));
    endproperty
    a_load_ignored: assert property (p_load_ignored) else $error("load taken while disabled");

    property p_seed_preset;
        (tx_load_rise && TESTER_ENABLE_I) |=> (q.tx_gen == $past(seed));
    endproperty
    a_seed_preset: assert property (p_seed_preset) else $error("tx seed not preset");

    property p_level_no_load;
        (TESTER_ENABLE_I && q.rx_load_q && RX_NEW_PATTERN_LOAD_I && !rx_bit)
            |=> (q.rx_gen == $past(q.rx_gen));
    endproperty
    a_level_no_load: assert property (p_level_no_load) else $error("load on level");

    property p_err_flag;
        ERROR_PRESENT_FLAG_O == (q.err_run != '0);
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("error flag wrong");

    property p_oos_flag;
        OUT_OF_LOCK_FLAG_O == (q.rx_st != bert_pkg::BERT_ST_SYNC);
    endproperty
    a_oos_flag: assert property (p_oos_flag) else $error("out of lock flag wrong");

    property p_update;
        pmu_rise |=> (BIT_COUNT_O == $past(q.bit_run)) && (ERROR_COUNT_O == $past(q.err_run))
                     && (q.bit_run <= 32'h00000001);
    endproperty
    a_update: assert property (p_update) else $error("monitor update wrong");

    property p_no_count_unlocked;
        (q.rx_st != bert_pkg::BERT_ST_SYNC && !pmu_rise) |=> $stable(q.bit_run) && $stable(q.err_run);
    endproperty
    a_no_count_unlocked: assert property (p_no_count_unlocked) else $error("count while unlocked");

    property p_count_locked;
        (!OUT_OF_LOCK_FLAG_O && TESTER_ENABLE_I && !rx_load_rise && rx_bit && !pmu_rise
            && q.bit_run != '1) |=> (q.bit_run == $past(q.bit_run) + 32'h00000001);
    endproperty
    a_count_locked: assert property (p_count_locked) else $error("bit not counted");

    property p_check_len;
        (q.rx_st == bert_pkg::BERT_ST_CHECK && d.rx_st == bert_pkg::BERT_ST_SYNC)
            |-> (q.rx_cnt == CNT_LAST) && !rx_miss;
    endproperty
    a_check_len: assert property (p_check_len) else $error("lock before 32 matches");

    property p_resync;
        (q.rx_st == bert_pkg::BERT_ST_SYNC && TESTER_ENABLE_I && !rx_load_rise && rx_bit
         && win_err_n == WIN_LIM && !AUTO_RESYNC_DIS_I) |=> OUT_OF_LOCK_FLAG_O;
    endproperty
    a_resync: assert property (p_resync) else $error("no resync after six errors");

    property p_zero_escape;
        (!rep_mode && q.rx_gen[30:0] == '0) |-> rx_fb;
    endproperty
    a_zero_escape: assert property (p_zero_escape) else $error("zero lock-up");

    property p_fifo_reset;
        RX_FIFO_RESET_I |=> !CP_VALID_O;
    endproperty
    a_fifo_reset: assert property (p_fifo_reset) else $error("fifo not held in reset");

    c_lock: cover property ($fell(OUT_OF_LOCK_FLAG_O));
    c_relock: cover property ($rose(OUT_OF_LOCK_FLAG_O) && TESTER_ENABLE_I);
    c_update: cover property (pmu_rise && q.err_run != '0);
    c_fifo_full: cover property (RX_VALID_I && !RX_READY_O);
    c_prbs2047: cover property (PATTERN_CTRL_I == bert_pkg::PCR_PRBS_2047 && !OUT_OF_LOCK_FLAG_O);
endmodule

// file: bert_fmodel.sv
// framer payload model: loops pattern bits back into the receive side
`timescale 1ns/100ps
module bert_fmodel (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset, low
    input wire logic run_i, // ask for bits
    input wire logic tx_data_i, // pattern bit
    input wire logic rx_ready_i, // bit taken
    output logic tx_slot_o, // slot request
    output logic rx_valid_o, // bit offered
    output logic rx_data_o // offered bit
);
    logic got_q;
    logic bit_q;
    // one bit in flight keeps the slot and the offer from overlapping
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {tx_slot_o, got_q, rx_valid_o, bit_q} <= 4'h0;
        end else begin
            got_q <= tx_slot_o;
            tx_slot_o <= run_i & ~tx_slot_o & ~got_q & ~rx_valid_o;
            if (got_q) begin
                rx_valid_o <= 1'b1;
                bit_q <= tx_data_i;
            end else if (rx_ready_i) begin
                rx_valid_o <= 1'b0;
            end
        end
    end
    // released line shows the inverse so a stale bit never matches
    assign rx_data_o = rx_valid_o ? bit_q : ~bit_q;
endmodule

// file: bert_top_test.sv
// self-checking bench for the bit error rate tester
`timescale 1ns/100ps
module bert_top_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b0, tl = 1'b0, rl = 1'b0, lmu = 1'b0, ffr = 1'b0, cpr = 1'b0;
    logic run = 1'b0, inv = 1'b0, se = 1'b0, ard = 1'b0, src = 1'b0, mei = 1'b0, pay = 1'b1;
    logic [2:0] rate = 3'h0;
    logic [15:0] pcr = 16'h080a, sl = 16'hffff, sh = 16'hffff;
    logic slot, txd, rv, rd, rrdy, cpv, efl, out_of_lock_flag;
    logic [7:0] cpd;
    logic [31:0] bc;
    logic [23:0] ec;
    int num_errors = 0, comparisons = 0, n;
    always #12.5 clk = ~clk;
    bert_top DUT (.MCLK_I(clk), .RST_N_I(rst_n), .TESTER_ENABLE_I(en), .PATTERN_CTRL_I(pcr),
        .SEED_LOW_I(sl), .SEED_HIGH_I(sh), .TX_NEW_PATTERN_LOAD_I(tl),
        .RX_NEW_PATTERN_LOAD_I(rl), .TX_PATTERN_INVERT_I(inv), .RX_PATTERN_INVERT_I(inv),
        .AUTO_RESYNC_DIS_I(ard), .ERROR_RATE_I(rate), .ERROR_SRC_PIN_I(src),
        .SINGLE_ERROR_I(se), .MANUAL_ERROR_INPUT_I(mei), .LOCAL_MONITOR_UPDATE_I(lmu),
        .RX_FIFO_RESET_I(ffr), .TX_SLOT_I(slot), .TX_DATA_O(txd), .RX_VALID_I(rv),
        .RX_DATA_I(rd), .RX_PAYLOAD_I(pay), .RX_READY_O(rrdy), .CP_VALID_O(cpv),
        .CP_DATA_O(cpd), .CP_READY_I(cpr), .ERROR_PRESENT_FLAG_O(efl),
        .OUT_OF_LOCK_FLAG_O(out_of_lock_flag), .BIT_COUNT_O(bc), .ERROR_COUNT_O(ec));
    bert_fmodel PARTNER (.clk_i(clk), .rst_n_i(rst_n), .run_i(run), .tx_data_i(txd),
        .rx_ready_i(rrdy), .tx_slot_o(slot), .rx_valid_o(rv), .rx_data_o(rd));
    // inputs move only on the falling edge
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic loads();
        {tl, rl} = 2'b00;
        cyc(2);
        {tl, rl} = 2'b11;
        cyc(2);
    endtask
    task automatic update();
        lmu = 1'b1;
        cyc(2);
        lmu = 1'b0;
        cyc(2);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog: the sequence needs about 5000 cycles
    initial begin
        cyc(9000);
        num_errors++;
        summarize();
    end
    initial begin
        cyc(6);
        rst_n = 1'b1;
        run = 1'b1;
        loads();
        cyc(400);
        chk("out_of_lock", 1, out_of_lock_flag);
        chk("tx_data", 0, txd);
        chk("rx_ready", 0, rrdy);
        ffr = 1'b1;
        cyc(2);
        chk("rx_ready", 1, rrdy);
        chk("cp_valid", 0, cpv);
        {ffr, cpr, en} = 3'b011;
        loads();
        cyc(800);
        chk("out_of_lock", 0, out_of_lock_flag);
        update();
        chk("error_count", 0, ec);
        chk("bits_counted", 1, |bc);
        se = 1'b1;
        cyc(40);
        chk("error_flag", 1, efl);
        update();
        chk("error_count", 1, ec);
        chk("error_flag", 0, efl);
        {rate, ard} = {3'h1, 1'b1};
        cyc(400);
        chk("out_of_lock", 0, out_of_lock_flag);
        ard = 1'b0;
        cyc(400);
        chk("out_of_lock", 1, out_of_lock_flag);
        rate = 3'h0;
        cyc(800);
        chk("out_of_lock", 0, out_of_lock_flag);
        update();
        {src, mei} = 2'b11;
        cyc(40);
        pay = 1'b0;
        update();
        chk("error_count", 1, ec);
        cyc(100);
        update();
        chk("bit_count", 0, bc);
        chk("out_of_lock", 0, out_of_lock_flag);
        {pay, pcr} = {1'b1, 16'h0253};
        loads();
        cyc(800);
        chk("out_of_lock", 0, out_of_lock_flag);
        {pcr, sl, inv} = {16'h0021, 16'hfffe, 1'b1};
        loads();
        cyc(800);
        chk("out_of_lock", 0, out_of_lock_flag);
        cpr = 1'b0;
        n = 0;
        while (rrdy !== 1'b0 && n < 2000) begin
            cyc(1);
            n++;
        end
        chk("fifo_byte", 1, cpd == 8'haa || cpd == 8'h55);
        cpr = 1'b1;
        n = 0;
        repeat (8) begin
            n += (cpv === 1'b1);
            cyc(1);
        end
        chk("fifo_depth", 8, n);
        chk("cp_valid", 0, cpv);
        summarize();
    end
endmodule
